// ---- verilog/ptm_pkg.sv ----
// package of the teach-mode key interpreter: constants, states, carriers
// assumes a 25 MHz system clock and an APB bus with 32-bit data
package ptm_pkg;
   localparam int unsigned CLK_HZ     = 25_000_000;
   localparam int unsigned MS_PER_S   = 1000;
   localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S;
   localparam int unsigned TBL_DEPTH  = 100;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_KEYINT  = 8'h08;
   localparam logic [7:0] OFS_JOGDIST = 8'h0C;
   localparam logic [7:0] OFS_VRUN    = 8'h10;
   localparam logic [7:0] OFS_VSTART  = 8'h14;
   localparam logic [7:0] OFS_TACC    = 8'h18;
   localparam logic [7:0] OFS_TDEC    = 8'h1C;
   localparam logic [7:0] OFS_TBLIDX  = 8'h20;
   localparam logic [7:0] OFS_TBLDATA = 8'h24;
   localparam logic [7:0] OFS_REPPOS  = 8'h28;
   // control field positions
   localparam int unsigned CB_TEACH = 0;
   localparam int unsigned CB_SAVE  = 1;
   localparam int unsigned CB_BRAKE = 2;
   localparam int unsigned CB_ENC   = 3;
   localparam int unsigned CB_PANIC = 4;
   localparam int unsigned CB_PLIM  = 5;
   localparam int unsigned CB_NLIM  = 6;
   localparam int unsigned CB_CON   = 7;
   // limits and reset values, jog distance in thousandths of a revolution
   localparam logic [31:0] KEYINT_MIN = 32'h0000_0032;
   localparam logic [31:0] KEYINT_MAX = 32'h0000_01F4;
   localparam logic [8:0]  KEYINT_RST = 9'h064;
   localparam logic [31:0] JOG_MIN    = 32'h0000_0001;
   localparam logic [31:0] JOG_MAX    = 32'h1DCD_6500;
   localparam logic [31:0] JOG_RST    = 32'h0000_0001;
   localparam logic [31:0] POS_MIN    = 32'h0000_0001;
   localparam logic [31:0] POS_MAX    = 32'h0000_0064;
   // key characters
   localparam logic [7:0] K_V = 8'h56, K_B = 8'h42, K_N = 8'h4E, K_M = 8'h4D;
   localparam logic [7:0] K_Q = 8'h51, K_K = 8'h4B, K_D = 8'h44, K_F = 8'h46;
   localparam logic [7:0] K_S = 8'h53, K_SP = 8'h20, K_CR = 8'h0D, K_ESC = 8'h1B;
   localparam logic [7:0] K_DOT = 8'h2E, K_0 = 8'h30, K_9 = 8'h39;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_TEACH = 4'h2,
      ST_ENTRY = 4'h4,
      ST_SAVE  = 4'h8
   } ptm_state_t;
   typedef enum logic [1:0] {
      EN_KEYINT = 2'h0,
      EN_JOG    = 2'h1,
      EN_POS    = 2'h2
   } ptm_entry_t;
   // command bundle toward the motion generator
   typedef struct packed {
      logic run;        // continuous motion level
      logic dir_pos;    // 1 positive, 0 negative
      logic jog;        // one jog step, pulse
      logic soft_stop;  // decelerating stop, pulse
      logic hard_stop;  // immediate stop, pulse
      logic zero_pos;   // clear current position, pulse
   } ptm_motion_t;
   // one word toward nonvolatile storage
   typedef struct packed {
      logic        we;
      logic [6:0]  addr;
      logic [31:0] data;
   } ptm_nvm_t;
endpackage

// ---- verilog/ptm_teach.sv ----
// teach-mode key interpreter with APB registers and position table
// assumes: key characters from a uart on pclk, motion generator on pclk,
// encoder and switch inputs asynchronous pins
// Behaviour
// - hold a hundred-entry position table
// - refuse teach during sequence or motion
// - teach ignores sequences, honours configured inputs
// - report commanded position continuously
// - current off reports encoder, else zero
// - V/M run continuously, soft stop on release
// - B/N jog by jog distance, repeating
// - Q toggles motor current
// - F toggles shaft free or brake
// - K sets key interval 50..500 ms
// - D sets jog distance, default 0.001
// - S or command saves table, never automatically
// - space hard stops immediately
// - enter prompts index, stores, confirms
// - escape soft stops and leaves teach
// - key timeout stops continuous motion with decel
// - Q off without encoder zeroes position
// - motions use run/start velocity, ramps
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ptm_teach
   import ptm_pkg::*;
#(
   parameter int unsigned P_MS_CYCLES = ptm_pkg::MS_CYCLES
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata_q,
   output logic                    pready_q,
   output logic                    pslverr_q,
   input  wire logic               key_valid,
   input  wire logic [7:0]         key_char,
   input  wire logic               seq_running,
   input  wire logic               motion_busy,
   input  wire logic [31:0]        commanded_position,
   input  wire logic               encoder_phase_a,
   input  wire logic               encoder_phase_b,
   input  wire logic               panic_stop_input,
   input  wire logic               positive_limit_input,
   input  wire logic               negative_limit_input,
   input  wire logic               current_on_input,
   input  wire logic               nvm_ready,
   output ptm_pkg::ptm_motion_t    motion_q,
   output ptm_pkg::ptm_nvm_t       nvm_q,
   output logic      [31:0]        jog_dist_q,
   output logic      [31:0]        running_velocity_q,
   output logic      [31:0]        starting_velocity_q,
   output logic      [31:0]        accel_time_q,
   output logic      [31:0]        decel_time_q,
   output logic                    teach_active_q,
   output logic                    current_drive_q,
   output logic                    brake_release_q,
   output logic      [31:0]        report_pos_q,
   output logic                    report_stb_q,
   output logic                    prompt_q,
   output logic                    store_ok_q,
   output logic                    store_err_q,
   output logic                    save_done_q
);
   import ptm_pkg::*;

   if (P_MS_CYCLES < 1 || P_MS_CYCLES > 32'h00FF_FFFF) begin : g_chk
      $error("P_MS_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [5:0] pin_m_q, pin_s_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_m_q <= 6'h00;
         pin_s_q <= 6'h00;
      end else begin
         pin_m_q <= {current_on_input, negative_limit_input, positive_limit_input,
                     panic_stop_input, encoder_phase_b, encoder_phase_a};
         pin_s_q <= pin_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers and state
   ptm_state_t  st_q;
   ptm_entry_t  ent_q;
   logic [5:0]  cfg_q;
   logic [8:0]  keyint_q, kms_q;
   logic [23:0] pre_q;
   logic [31:0] tbl_q [TBL_DEPTH];
   logic [6:0]  tidx_q, sidx_q;
   logic [31:0] acc_q, enc_q;
   logic [1:0]  frac_q, encp_q;
   logic        dot_q, cur_q, free_q, run_q, dir_q;
   logic        ret_teach_q, req_teach_q, req_save_q;

   // apb decode
   wire         apb_setup  = psel && !penable;
   wire         apb_wr     = psel && penable && pready_q && pwrite;
   wire         wr_ctrl    = apb_wr && paddr == OFS_CTRL;
   wire         addr_ok    = paddr <= OFS_REPPOS && paddr[1:0] == 2'h0;
   wire         brake_mode = cfg_q[CB_BRAKE - 2];
   wire         enc_on     = cfg_q[CB_ENC - 2];
   wire         panic      = cfg_q[CB_PANIC - 2] && pin_s_q[2];
   wire         plim       = cfg_q[CB_PLIM - 2] && pin_s_q[3];
   wire         nlim       = cfg_q[CB_NLIM - 2] && pin_s_q[4];
   wire         con_ok     = !cfg_q[CB_CON - 2] || pin_s_q[5];
   wire [31:0]  status     = {26'h0, cur_q, free_q, run_q, st_q == ST_SAVE,
                              st_q != ST_IDLE && st_q != ST_SAVE, current_drive_q};
   wire [31:0]  rd_mux     = paddr == OFS_CTRL    ? {24'h0, cfg_q, 2'h0} :
                             paddr == OFS_STATUS  ? status :
                             paddr == OFS_KEYINT  ? {23'h0, keyint_q} :
                             paddr == OFS_JOGDIST ? jog_dist_q :
                             paddr == OFS_VRUN    ? running_velocity_q :
                             paddr == OFS_VSTART  ? starting_velocity_q :
                             paddr == OFS_TACC    ? accel_time_q :
                             paddr == OFS_TDEC    ? decel_time_q :
                             paddr == OFS_TBLIDX  ? {25'h0, tidx_q} :
                             paddr == OFS_TBLDATA ? tbl_q[tidx_q] :
                             paddr == OFS_REPPOS  ? report_pos_q : 32'h0;

   // key decode
   wire         in_teach   = st_q == ST_TEACH;
   wire         in_entry   = st_q == ST_ENTRY;
   wire         kt         = key_valid && in_teach;
   wire         ke         = key_valid && in_entry;
   wire         is_digit   = key_char >= K_0 && key_char <= K_9;
   wire [31:0]  digit      = {28'h0, key_char[3:0]};
   wire         moving     = run_q || motion_busy;
   wire         cont_key   = kt && (key_char == K_V || key_char == K_M);
   wire         jog_key    = kt && (key_char == K_B || key_char == K_N);
   wire         q_key      = kt && key_char == K_Q;
   wire         q_ignored  = moving && cur_q;
   wire         q_do       = q_key && !q_ignored;
   wire         ms_tick    = pre_q == 24'(P_MS_CYCLES - 1);
   wire         kto        = run_q && ms_tick && kms_q >= keyint_q;
   wire         teach_ok   = !seq_running && !motion_busy;
   wire         lim_hit    = run_q && (dir_q ? plim : nlim);

   // entry value scaled to thousandths for the jog distance
   wire [31:0]  scale      = frac_q == 2'h0 ? 32'h0000_03E8 :
                             frac_q == 2'h1 ? 32'h0000_0064 :
                             frac_q == 2'h2 ? 32'h0000_000A : 32'h0000_0001;
   wire [63:0]  milli_w    = acc_q * scale;
   wire [31:0]  milli      = milli_w[63:32] != 32'h0 ? 32'hFFFF_FFFF : milli_w[31:0];
   wire [31:0]  acc_next   = 32'(acc_q * 32'h0000_000A + digit);
   wire         ent_done   = ke && key_char == K_CR;
   wire         kint_ok    = acc_q >= KEYINT_MIN && acc_q <= KEYINT_MAX;
   wire         jog_ok     = milli >= JOG_MIN && milli <= JOG_MAX;
   wire         pos_ok     = acc_q >= POS_MIN && acc_q <= POS_MAX;
   wire [6:0]   pos_slot   = 7'(acc_q - 32'h1);
   wire         save_go    = st_q == ST_SAVE && nvm_q.we && nvm_ready;
   wire         save_last  = save_go && sidx_q == 7'(TBL_DEPTH - 1);

   ////////////////////////////////////////////////////////////////////////
   // apb slave, no wait states, error on unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= apb_setup;
         pslverr_q <= apb_setup && !addr_ok;
         if (apb_setup) prdata_q <= rd_mux;
      end
   end

   // software settings; motion profile handed to the motion generator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q               <= 6'h00;
         running_velocity_q  <= 32'h0;
         starting_velocity_q <= 32'h0;
         accel_time_q        <= 32'h0;
         decel_time_q        <= 32'h0;
         tidx_q              <= 7'h00;
      end else if (apb_wr) begin
         if (paddr == OFS_CTRL)   cfg_q <= pwdata[CB_CON:CB_BRAKE];
         if (paddr == OFS_VRUN)   running_velocity_q  <= pwdata;
         if (paddr == OFS_VSTART) starting_velocity_q <= pwdata;
         if (paddr == OFS_TACC)   accel_time_q <= pwdata;
         if (paddr == OFS_TDEC)   decel_time_q <= pwdata;
         if (paddr == OFS_TBLIDX && pwdata < TBL_DEPTH) tidx_q <= pwdata[6:0];
      end
   end

   // one-shot requests from the control word, served only if the state allows in the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_teach_q <= 1'b0;
         req_save_q  <= 1'b0;
      end else begin
         req_teach_q <= wr_ctrl && pwdata[CB_TEACH];
         req_save_q  <= wr_ctrl && pwdata[CB_SAVE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // millisecond prescaler and key interval timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 24'h0;
         kms_q <= 9'h000;
      end else begin
         pre_q <= ms_tick ? 24'h0 : pre_q + 24'h1;
         if (cont_key || jog_key) kms_q <= 9'h000;
         else if (ms_tick && kms_q != 9'h1FF) kms_q <= kms_q + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // quadrature counter; position tracks the shaft while current is off
   wire [1:0] enc_now = pin_s_q[1:0];
   wire       enc_chg = enc_now != encp_q;
   wire       enc_up  = enc_now[0] ^ encp_q[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         encp_q <= 2'h0;
         enc_q  <= 32'h0;
      end else begin
         encp_q <= enc_now;
         if (q_do && cur_q) enc_q <= commanded_position;
         else if (enc_chg && enc_now != ~encp_q) enc_q <= enc_up ? enc_q + 32'h1 : enc_q - 32'h1;
      end
   end

   // position report toward the host terminal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         report_pos_q <= 32'h0;
         report_stb_q <= 1'b0;
      end else begin
         report_pos_q <= cur_q ? commanded_position : (enc_on ? enc_q : 32'h0);
         report_stb_q <= ms_tick && st_q != ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q        <= ST_IDLE;
         ent_q       <= EN_POS;
         ret_teach_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (req_teach_q && teach_ok) st_q <= ST_TEACH;
               else if (req_save_q) begin
                  st_q        <= ST_SAVE;
                  ret_teach_q <= 1'b0;
               end
            end
            ST_TEACH: begin
               if (kt && key_char == K_ESC) st_q <= ST_IDLE;
               else if (kt && key_char == K_S) begin
                  st_q        <= ST_SAVE;
                  ret_teach_q <= 1'b1;
               end else if (kt && key_char == K_CR) begin
                  st_q  <= ST_ENTRY;
                  ent_q <= EN_POS;
               end else if (kt && key_char == K_K) begin
                  st_q  <= ST_ENTRY;
                  ent_q <= EN_KEYINT;
               end else if (kt && key_char == K_D) begin
                  st_q  <= ST_ENTRY;
                  ent_q <= EN_JOG;
               end
            end
            ST_ENTRY: begin
               if (ent_done || (ke && key_char == K_ESC)) st_q <= ST_TEACH;
            end
            ST_SAVE: begin
               if (save_last) st_q <= ret_teach_q ? ST_TEACH : ST_IDLE;
            end
         endcase
      end
   end

   // numeric entry and its results
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q      <= 32'h0;
         frac_q     <= 2'h0;
         dot_q      <= 1'b0;
         keyint_q   <= KEYINT_RST;
         jog_dist_q <= JOG_RST;
         store_ok_q <= 1'b0;
         store_err_q <= 1'b0;
         prompt_q   <= 1'b0;
      end else begin
         store_ok_q  <= 1'b0;
         store_err_q <= 1'b0;
         prompt_q    <= kt && key_char == K_CR;
         if (!in_entry) begin
            acc_q  <= 32'h0;
            frac_q <= 2'h0;
            dot_q  <= 1'b0;
         end else if (ke && is_digit && !(dot_q && frac_q == 2'h3)) begin
            acc_q <= acc_next;
            if (dot_q) frac_q <= frac_q + 2'h1;
         end else if (ke && key_char == K_DOT && ent_q == EN_JOG) begin
            dot_q <= 1'b1;
         end
         if (ent_done) begin
            unique case (ent_q)
               EN_KEYINT: if (kint_ok) keyint_q <= acc_q[8:0];
               EN_JOG:    if (jog_ok) jog_dist_q <= milli;
               EN_POS: begin
                  store_ok_q  <= pos_ok;
                  store_err_q <= !pos_ok;
               end
               default: ;
            endcase
         end
      end
   end

   // position table; written only by a confirmed store
   always_ff @(posedge pclk) begin
      if (ent_done && ent_q == EN_POS && pos_ok) tbl_q[pos_slot] <= report_pos_q;
   end

   // table save to nonvolatile storage, one word per handshake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sidx_q      <= 7'h00;
         nvm_q       <= '0;
         save_done_q <= 1'b0;
      end else begin
         save_done_q <= save_last;
         if (st_q != ST_SAVE) begin
            sidx_q <= 7'h00;
            nvm_q  <= '0;
         end else begin
            nvm_q.we   <= !save_last;
            nvm_q.addr <= save_go ? sidx_q + 7'h01 : sidx_q;
            nvm_q.data <= tbl_q[save_go && !save_last ? sidx_q + 7'h01 : sidx_q];
            if (save_go) sidx_q <= sidx_q + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // motion commands, current and brake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motion_q <= '0;
         run_q    <= 1'b0;
         dir_q    <= 1'b0;
         cur_q    <= 1'b1;
         free_q   <= 1'b0;
      end else begin
         motion_q.jog       <= 1'b0;
         motion_q.soft_stop <= 1'b0;
         motion_q.hard_stop <= 1'b0;
         motion_q.zero_pos  <= 1'b0;
         if ((kt && key_char == K_SP) || (in_teach && (panic || lim_hit))) begin
            run_q              <= 1'b0;
            motion_q.hard_stop <= 1'b1;
         end else if ((kt && key_char == K_ESC) || kto) begin
            run_q              <= 1'b0;
            motion_q.soft_stop <= 1'b1;
         end else if (cont_key && current_drive_q) begin
            run_q <= 1'b1;
            dir_q <= key_char == K_M;
         end else if (jog_key && current_drive_q && !run_q) begin
            motion_q.jog <= 1'b1;
            dir_q        <= key_char == K_N;
         end
         if (q_do) begin
            cur_q             <= !cur_q;
            motion_q.zero_pos <= cur_q && !enc_on;
         end
         if (kt && key_char == K_F) free_q <= !free_q;
         motion_q.run     <= run_q;
         motion_q.dir_pos <= dir_q;
      end
   end

   // drive outputs; free with brake mode off drops current as well
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_drive_q <= 1'b0;
         brake_release_q <= 1'b0;
         teach_active_q  <= 1'b0;
      end else begin
         current_drive_q <= cur_q && !(free_q && !brake_mode) && con_ok;
         brake_release_q <= free_q;
         teach_active_q  <= st_q != ST_IDLE && !(st_q == ST_SAVE && !ret_teach_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_teach_refuse: assert property (st_q == ST_IDLE && !teach_ok |=> st_q != ST_TEACH)
      else $error("teach entered while busy");
   a_report_src: assert property (!cur_q && !enc_on |=> report_pos_q == 32'h0)
      else $error("position not zero without encoder");
   a_space_stop: assert property (kt && key_char == K_SP |=> motion_q.hard_stop ##1 !motion_q.run)
      else $error("space did not hard stop");
   a_esc_leave: assert property (kt && key_char == K_ESC |=> st_q == ST_IDLE && motion_q.soft_stop)
      else $error("escape did not leave teach");
   a_q_toggle: assert property (q_do |=> cur_q != $past(cur_q))
      else $error("current not toggled");
   a_q_zero: assert property (q_do && cur_q && !enc_on |=> motion_q.zero_pos)
      else $error("position not cleared");
   a_key_timeout: assert property (kto && !(kt && key_char == K_SP) |=> motion_q.soft_stop ##1 !motion_q.run)
      else $error("timeout did not stop");
   a_keyint_range: assert property (keyint_q >= 9'h032 && keyint_q <= 9'h1F4)
      else $error("key interval out of range");
   a_jog_range: assert property (jog_dist_q >= JOG_MIN && jog_dist_q <= JOG_MAX)
      else $error("jog distance out of range");
   a_save_only_req: assert property (st_q != ST_SAVE ##1 st_q == ST_SAVE |->
                                     $past(req_save_q) || $past(kt && key_char == K_S))
      else $error("save without request");
   a_store_ack: assert property (ent_done && ent_q == EN_POS |=> store_ok_q != store_err_q)
      else $error("store not answered");

   c_cont_run: cover property (cont_key ##[1:50] kto);
   c_store_pos: cover property (prompt_q ##[1:40] store_ok_q);
   c_save_all: cover property (st_q == ST_SAVE ##[1:400] save_done_q);
endmodule

// ---- dv/ptm_host.sv ----
// host terminal model: sends key characters
// assumes the interpreter takes a key at an edge with key_valid high
`timescale 1ns/1ps
module ptm_host (
   input  wire logic       pclk,
   output logic            key_valid,
   output logic [7:0]      key_char
);
   initial key_valid = 1'b0;
   initial key_char = 8'h00;
   // one-cycle strobe; the released line shows the inverse of the last key
   task automatic send(input logic [7:0] c);
      @(posedge pclk);
      key_valid <= 1'b1;
      key_char <= c;
      @(posedge pclk);
      key_valid <= 1'b0;
      key_char <= ~c;
   endtask
endmodule

// ---- dv/ptm_teach_tb.sv ----
// teach-mode bench: apb master, host model, pulse waits
// assumes ptm_pkg, ptm_teach and ptm_host are compiled first
`timescale 1ns/1ps
module ptm_teach_tb;
   import ptm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, seq_running = 0, motion_busy = 0;
   logic nvm_ready = 1, pready_q, pslverr_q, key_valid, teach_active_q, current_drive_q, er;
   logic prompt_q, store_ok_q, save_done_q, brk;
   logic [5:0] pins = 6'h00; // enc b, enc a, panic, +lim, -lim, current
   logic [7:0] paddr = 8'h00, key_char;
   logic [31:0] pwdata = 32'h0, cpos = 32'h0000_1234, prdata_q, rd, rpos, nv4;
   logic [7:0] ev;
   ptm_motion_t motion_q;
   ptm_nvm_t nvm_q;
   int err_count = 0, n_checks = 0, n_words = 0;
   // pulses and levels a scenario can wait on
   assign ev = {motion_q.jog, save_done_q, store_ok_q, prompt_q, motion_q.zero_pos,
                motion_q.soft_stop, motion_q.hard_stop, motion_q.run};
   always #20 pclk = ~pclk;
   // storage side: ready every other cycle, count accepted words, keep word 4
   always @(posedge pclk) begin
      nvm_ready <= ~nvm_ready;
      if (nvm_q.we && nvm_ready) n_words++;
      if (nvm_q.we && nvm_ready && nvm_q.addr == 7'h04) nv4 = nvm_q.data;
   end
   ptm_host host (.pclk(pclk), .key_valid(key_valid), .key_char(key_char));
   ptm_teach #(.P_MS_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
      .pslverr_q(pslverr_q), .key_valid(key_valid), .key_char(key_char), .seq_running(seq_running),
      .motion_busy(motion_busy), .commanded_position(cpos), .encoder_phase_a(pins[4]), .encoder_phase_b(pins[5]),
      .panic_stop_input(pins[3]), .positive_limit_input(pins[2]), .negative_limit_input(pins[1]),
      .current_on_input(pins[0]), .nvm_ready(nvm_ready), .motion_q(motion_q), .nvm_q(nvm_q), .jog_dist_q(),
      .running_velocity_q(), .starting_velocity_q(), .accel_time_q(), .decel_time_q(),
      .teach_active_q(teach_active_q), .current_drive_q(current_drive_q), .brake_release_q(brk),
      .report_pos_q(rpos), .report_stb_q(), .prompt_q(prompt_q), .store_ok_q(store_ok_q), .store_err_q(),
      .save_done_q(save_done_q));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_q !== 1'b1);
      rd = prdata_q;
      er = pslverr_q;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // wait up to n cycles for event s
   task automatic wt(input int s, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge pclk);
         if (ev[s] === 1'b1) break;
      end
      chk({31'h0, i < n}, 32'h1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_reg();
      apb(0, OFS_JOGDIST, 0);
      chk(rd, JOG_RST);
      apb(0, OFS_KEYINT, 0);
      chk(rd, 32'h0000_0064);
      apb(0, 8'hFC, 0);
      chk({31'h0, er}, 32'h1);
      motion_busy <= 1'b1;
      apb(1, OFS_CTRL, 32'h0000_0011);
      repeat (3) @(posedge pclk);
      chk({31'h0, teach_active_q}, 32'h0);
      motion_busy <= 1'b0;
      apb(1, OFS_CTRL, 32'h0000_0011);
      repeat (3) @(posedge pclk);
      chk({31'h0, teach_active_q}, 32'h1);
      $display("registers and entry done");
   endtask
   task automatic t_run();
      chk(rpos, cpos);
      host.send(K_M);
      wt(0, 5);
      chk({31'h0, motion_q.dir_pos}, 32'h1);
      wt(2, 1100);
      host.send(K_M);
      pins[3] <= 1'b1;
      wt(1, 10);
      pins[3] <= 1'b0;
      repeat (3) @(posedge pclk);
      host.send(K_V);
      wt(0, 5);
      chk({31'h0, motion_q.dir_pos}, 32'h0);
      host.send(K_SP);
      wt(1, 5);
      repeat (5) @(posedge pclk);
      host.send(K_Q);
      wt(3, 5);
      @(posedge pclk);
      chk({31'h0, current_drive_q}, 32'h0);
      chk(rpos, 32'h0);
      host.send(K_Q);
      repeat (3) @(posedge pclk);
      chk({31'h0, current_drive_q}, 32'h1);
      $display("motion keys done");
   endtask
   task automatic t_store();
      host.send(K_CR);
      wt(4, 5);
      keys("5\r");
      wt(5, 5);
      apb(1, OFS_TBLIDX, 32'h4);
      apb(0, OFS_TBLDATA, 0);
      chk(rd, cpos);
      host.send(K_S);
      wt(6, 400);
      chk(n_words, 32'd100);
      chk(nv4, cpos);
      host.send(K_ESC);
      wt(2, 5);
      repeat (2) @(posedge pclk);
      chk({31'h0, teach_active_q}, 32'h0);
      $display("store save exit done");
   endtask
   // a string of keys, one after the other
   task automatic keys(input string s);
      for (int i = 0; i < s.len(); i++) host.send(s[i]);
   endtask
   task automatic t_keys();
      host.send(K_N);
      wt(7, 5);
      @(posedge pclk);
      chk({31'h0, motion_q.dir_pos}, 32'h1);
      keys("K60\r");
      apb(0, OFS_KEYINT, 0);
      chk(rd, 32'h0000_003C);
      keys("K9\r");
      apb(0, OFS_KEYINT, 0);
      chk(rd, 32'h0000_003C);
      keys("D2.5\r");
      apb(0, OFS_JOGDIST, 0);
      chk(rd, 32'h0000_09C4);
      host.send(K_F);
      repeat (2) @(posedge pclk);
      chk({30'h0, brk, current_drive_q}, 32'h2);
      host.send(K_F);
      $display("entry keys done");
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reg();
      t_run();
      t_keys();
      t_store();
      complete_run();
   end
   // watchdog
   initial begin
      repeat (6000) @(posedge pclk);
      err_count++;
      complete_run();
   end
endmodule
